// >>> hdl/sfw_pkg.sv
// Purpose: shared constants and types of the serial memory write path
// Assumes: one system clock; serial pins are sampled, not used as clocks
// Notes:   opcodes, field sizes and state codes live here only
package sfw_pkg;

   // write opcodes accepted by the command decoder
   localparam logic [7:0] OP_WRITE       = 8'h02;
   localparam logic [7:0] OP_DDR_WRITE   = 8'hDE;
   localparam logic [7:0] OP_FAST_WRITE  = 8'hDA;
   localparam logic [7:0] OP_DDR_FAST    = 8'hDD;
   localparam logic [7:0] OP_DUAL_DATA   = 8'hA2;
   localparam logic [7:0] OP_DUAL_ADDR   = 8'hA1;
   localparam logic [7:0] OP_QUAD_DATA   = 8'h32;
   localparam logic [7:0] OP_QUAD_ADDR   = 8'hD2;
   localparam logic [7:0] OP_DDR_QUAD    = 8'hD1;

   // field sizes and address space
   localparam int          ADDR_BITS     = 18;
   localparam logic [4:0]  BYTE_BITS     = 5'h08;
   localparam logic [4:0]  ADDR_FIELD    = 5'h18;
   localparam logic [4:0]  CNT_ZERO      = 5'h00;
   localparam logic [17:0] ADDR_TOP      = 18'h3_FFFF;
   localparam logic [17:0] ADDR_ZERO     = 18'h0_0000;
   localparam logic [17:0] ADDR_ONE      = 18'h0_0001;
   localparam logic [3:0]  XIP_NIBBLE    = 4'hA;

   // lane counts of one serial beat
   localparam logic [2:0]  LANES_1       = 3'h1;
   localparam logic [2:0]  LANES_2       = 3'h2;
   localparam logic [2:0]  LANES_4       = 3'h4;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'b00_0001,
      ST_OPCODE = 6'b00_0010,
      ST_ADDR   = 6'b00_0100,
      ST_MODE   = 6'b00_1000,
      ST_DATA   = 6'b01_0000,
      ST_SKIP   = 6'b10_0000
   } sfw_state_t;

   // lane and rate plan of one decoded command
   typedef struct packed {
      logic       legal;
      logic       ddr;
      logic       hasMode;
      logic [2:0] addrLanes;
      logic [2:0] dataLanes;
   } sfw_cmd_t;

   // one array write as it travels through the buffer
   typedef struct packed {
      logic [17:0] addr;
      logic [7:0]  data;
   } sfw_wr_t;

   // whole state of the command engine
   typedef struct packed {
      logic        csMeta;
      logic        csSafe;
      logic        sckMeta;
      logic        sckSafe;
      logic        sckPrev;
      logic [3:0]  ioMeta;
      logic [3:0]  ioSafe;
      sfw_state_t  state;
      sfw_cmd_t    cmd;
      logic [23:0] shift;
      logic [4:0]  bitCnt;
      logic [17:0] addr;
      logic        execute_in_place;
      sfw_cmd_t    xipCmd;
      logic        outValid;
      sfw_wr_t     outWord;
      logic        overrun;
   } sfw_core_t;

endpackage

// >>> hdl/sfw_fifo.sv
// Purpose: write buffer between serial decoder and array port
// Assumes: DEPTH is a power of two
// Notes:   full and empty come from pointers with one wrap bit
`timescale 1ns/100ps
module sfw_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW:0] wrPtr;
      logic [PW:0] rdPtr;
   } sfw_fifo_st_t;

   sfw_fifo_st_t     st_reg;
   sfw_fifo_st_t     st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
         $error("sfw_fifo: DEPTH must be a power of two >= 2");
   end

   // full when pointers differ only in the wrap bit
   assign inReady  = !((st_reg.wrPtr[PW] != st_reg.rdPtr[PW]) &&
                       (st_reg.wrPtr[PW-1:0] == st_reg.rdPtr[PW-1:0]));
   assign outValid = (st_reg.wrPtr != st_reg.rdPtr);
   assign outData  = mem[st_reg.rdPtr[PW-1:0]];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // pointer advance
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wrPtr = st_reg.wrPtr + 1'b1;
      end
      if (pop) begin
         st_next.rdPtr = st_reg.rdPtr + 1'b1;
      end
   end

   // storage has no reset; only the pointers say what is valid
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
      if (push) begin
         mem[st_reg.wrPtr[PW-1:0]] <= inData;
      end
   end

endmodule

// >>> hdl/sfw_write_path.sv
// Purpose: command decode and write path of a serial memory, oversampling the host pins
// Assumes: ref_clk at least four times the serial clock; lanes only received here
// Notes:   opcode is always single rate; double rate applies from the address on
// Notes on behaviour
// - any burst length, no page limit
// - keep 18 address bits, drop bits 23..18
// - data follows last address or mode bit
// - protected addresses count but never write
// - only whole bytes reach the array
// - 02 is basic write, single rate
// - DE double rate, quad protocol only
// - DA has mode byte, DD double-rate twin
// - A2 serial header, data on two lanes
// - A1 opcode serial, rest on two lanes
// - 32 serial header, data on four lanes
// - D2 opcode serial, rest four lanes; D1 double
// - basic write uses protocol lane count
// - address steps up after each byte
// - counter wraps from top to zero
// - basic write needs write enable latch
// - basic write leaves latch set
// - double rate samples both clock edges
// - double rate write gated, latch kept
// - double rate counter wraps to zero
// - mode nibble A enters continuous mode
// - any other mode byte leaves it
// - two lanes: bit 7 on lane 1 first
// - four lanes: upper nibble first, bit 7 lane 3
`timescale 1ns/100ps
module sfw_write_path #(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        csN,
   input  wire logic        sck,
   input  wire logic [3:0]  ioIn,
   input  wire logic        dualLaneProtocol,
   input  wire logic        quadLaneProtocol,
   input  wire logic        writeEnableLatch,
   input  wire logic        protEn,
   input  wire logic [17:0] protLo,
   input  wire logic [17:0] protHi,
   input  wire logic        memWrReady,
   output logic             memWrValid,
   output logic      [17:0] memWrAddr,
   output logic      [7:0]  memWrData,
   output logic             xipActive,
   output logic             overrun,
   output logic             busy
);
   localparam int WORD_W = $bits(sfw_pkg::sfw_wr_t);

   initial begin
      if (FIFO_DEPTH < 2)
         $error("sfw_write_path: FIFO_DEPTH too small");
   end

   sfw_pkg::sfw_core_t r_reg;
   sfw_pkg::sfw_core_t r_next;

   logic              csActive;
   logic              sckRise;
   logic              sckFall;
   logic              sample;
   logic [2:0]        protW;
   logic [2:0]        beatW;
   logic [4:0]        cntNext;
   logic [23:0]       shiftNew;
   logic              pushReq;
   logic              fifoInReady;
   logic              fifoOutValid;
   logic              popReady;
   sfw_pkg::sfw_wr_t  pushWord;
   sfw_pkg::sfw_wr_t  fifoOutWord;
   sfw_pkg::sfw_cmd_t dec;

   // protected window test, used by the write gate and its check
   function automatic logic isProt(input logic [17:0] a, input logic en,
                                   input logic [17:0] lo, input logic [17:0] hi);
      isProt = en && (a >= lo) && (a <= hi);
   endfunction

   // next burst address; rolls over at the top of the array
   function automatic logic [17:0] addrStep(input logic [17:0] a);
      addrStep = (a == sfw_pkg::ADDR_TOP) ? sfw_pkg::ADDR_ZERO : a + sfw_pkg::ADDR_ONE;
   endfunction

   // shift a beat in msb first; lane 0, 1 or 3 carries the highest bit for one, two or four lanes
   function automatic logic [23:0] shiftIn(input logic [23:0] s, input logic [3:0] io,
                                           input logic [2:0] w);
      logic [23:0] v;
      v = s;
      unique case (w)
         sfw_pkg::LANES_4: v = {s[19:0], io[3:0]};
         sfw_pkg::LANES_2: v = {s[21:0], io[1:0]};
         default:          v = {s[22:0], io[0]};
      endcase
      shiftIn = v;
   endfunction

   // opcode to lane plan; illegal combinations of opcode and protocol are refused
   function automatic sfw_pkg::sfw_cmd_t decode(input logic [7:0] op, input logic dual,
                                                input logic quad, input logic [2:0] pw);
      sfw_pkg::sfw_cmd_t c;
      logic              single;
      single = !dual && !quad;
      c = '{legal: 1'b0, ddr: 1'b0, hasMode: 1'b0, addrLanes: pw, dataLanes: pw};
      unique case (op)
         sfw_pkg::OP_WRITE:      c.legal = 1'b1;
         sfw_pkg::OP_FAST_WRITE: begin
            c.legal   = 1'b1;
            c.hasMode = 1'b1;
         end
         sfw_pkg::OP_DDR_WRITE:  begin
            c.legal = quad;
            c.ddr   = 1'b1;
         end
         sfw_pkg::OP_DDR_FAST:   begin
            c.legal   = quad;
            c.ddr     = 1'b1;
            c.hasMode = 1'b1;
         end
         sfw_pkg::OP_DUAL_DATA:  begin
            c = '{legal: single, ddr: 1'b0, hasMode: 1'b1,
                  addrLanes: sfw_pkg::LANES_1, dataLanes: sfw_pkg::LANES_2};
         end
         sfw_pkg::OP_DUAL_ADDR:  begin
            c = '{legal: single, ddr: 1'b0, hasMode: 1'b1,
                  addrLanes: sfw_pkg::LANES_2, dataLanes: sfw_pkg::LANES_2};
         end
         sfw_pkg::OP_QUAD_DATA:  begin
            c = '{legal: single, ddr: 1'b0, hasMode: 1'b1,
                  addrLanes: sfw_pkg::LANES_1, dataLanes: sfw_pkg::LANES_4};
         end
         sfw_pkg::OP_QUAD_ADDR:  begin
            c = '{legal: single, ddr: 1'b0, hasMode: 1'b1,
                  addrLanes: sfw_pkg::LANES_4, dataLanes: sfw_pkg::LANES_4};
         end
         sfw_pkg::OP_DDR_QUAD:   begin
            c = '{legal: single, ddr: 1'b1, hasMode: 1'b1,
                  addrLanes: sfw_pkg::LANES_4, dataLanes: sfw_pkg::LANES_4};
         end
         default:                c.legal = 1'b0;
      endcase
      decode = c;
   endfunction

   // pin view after the synchronisers; the first stage feeds only the second
   assign csActive = !r_reg.csSafe;
   assign sckRise  = r_reg.sckSafe && !r_reg.sckPrev;
   assign sckFall  = !r_reg.sckSafe && r_reg.sckPrev;
   assign protW    = quadLaneProtocol ? sfw_pkg::LANES_4 :
                     dualLaneProtocol ? sfw_pkg::LANES_2 : sfw_pkg::LANES_1;
   assign beatW    = (r_reg.state == sfw_pkg::ST_OPCODE) ? protW :
                     (r_reg.state == sfw_pkg::ST_DATA)   ? r_reg.cmd.dataLanes : r_reg.cmd.addrLanes;

   // double rate takes the falling edge too, but never for the opcode; the fall that
   // closes the last opcode beat lands with an empty count and must not shift a bit in
   assign sample   = csActive && (sckRise || (sckFall && r_reg.cmd.ddr &&
                     (r_reg.bitCnt != sfw_pkg::CNT_ZERO) &&
                     (r_reg.state inside {sfw_pkg::ST_ADDR, sfw_pkg::ST_MODE, sfw_pkg::ST_DATA})));
   assign cntNext  = r_reg.bitCnt + {2'b00, beatW};
   assign shiftNew = shiftIn(r_reg.shift, r_reg.ioSafe, beatW);
   assign dec      = decode(shiftNew[7:0], dualLaneProtocol, quadLaneProtocol, protW);

   // a byte is pushed only once its eighth bit is in and its address is open
   assign pushReq  = (r_reg.state == sfw_pkg::ST_DATA) && sample && (cntNext == sfw_pkg::BYTE_BITS) &&
                     !isProt(r_reg.addr, protEn, protLo, protHi);
   assign pushWord = '{addr: r_reg.addr, data: shiftNew[7:0]};
   assign popReady = !r_reg.outValid || memWrReady;

   // the serial host cannot be stalled, so a full buffer drops the byte and flags it
   sfw_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .inValid  (pushReq),
      .inReady  (fifoInReady),
      .inData   (pushWord),
      .outValid (fifoOutValid),
      .outReady (popReady),
      .outData  (fifoOutWord)
   );

   // next-state logic of the whole engine
   always_comb begin
      r_next         = r_reg;
      r_next.csMeta  = csN;
      r_next.csSafe  = r_reg.csMeta;
      r_next.sckMeta = sck;
      r_next.sckSafe = r_reg.sckMeta;
      r_next.sckPrev = r_reg.sckSafe;
      r_next.ioMeta  = ioIn;
      r_next.ioSafe  = r_reg.ioMeta;

      // array side output stage
      if (popReady) begin
         r_next.outValid = fifoOutValid;
         r_next.outWord  = fifoOutWord;
      end
      if (pushReq && !fifoInReady) begin
         r_next.overrun = 1'b1;
      end

      if (!csActive) begin
         // select high aborts; a partial byte is simply forgotten
         r_next.state  = sfw_pkg::ST_IDLE;
         r_next.bitCnt = sfw_pkg::CNT_ZERO;
         r_next.cmd    = '0;
      end else begin
         unique case (r_reg.state)
            sfw_pkg::ST_IDLE: begin
               r_next.bitCnt = sfw_pkg::CNT_ZERO;
               if (r_reg.execute_in_place) begin
                  // continuous mode: the frame opens with the address
                  r_next.cmd   = r_reg.xipCmd;
                  r_next.state = writeEnableLatch ? sfw_pkg::ST_ADDR : sfw_pkg::ST_SKIP;
               end else begin
                  r_next.state = sfw_pkg::ST_OPCODE;
               end
            end
            sfw_pkg::ST_OPCODE: begin
               if (sample) begin
                  r_next.shift  = shiftNew;
                  r_next.bitCnt = cntNext;
                  if (cntNext == sfw_pkg::BYTE_BITS) begin
                     r_next.bitCnt = sfw_pkg::CNT_ZERO;
                     r_next.cmd    = dec;
                     // the latch is only read here, never cleared by this block
                     if (dec.legal && writeEnableLatch) begin
                        r_next.state = sfw_pkg::ST_ADDR;
                     end else begin
                        r_next.state = sfw_pkg::ST_SKIP;
                     end
                  end
               end
            end
            sfw_pkg::ST_ADDR: begin
               if (sample) begin
                  r_next.shift  = shiftNew;
                  r_next.bitCnt = cntNext;
                  if (cntNext == sfw_pkg::ADDR_FIELD) begin
                     r_next.bitCnt = sfw_pkg::CNT_ZERO;
                     r_next.addr   = shiftNew[sfw_pkg::ADDR_BITS-1:0];
                     r_next.state  = r_reg.cmd.hasMode ? sfw_pkg::ST_MODE : sfw_pkg::ST_DATA;
                  end
               end
            end
            sfw_pkg::ST_MODE: begin
               if (sample) begin
                  r_next.shift  = shiftNew;
                  r_next.bitCnt = cntNext;
                  if (cntNext == sfw_pkg::BYTE_BITS) begin
                     r_next.bitCnt = sfw_pkg::CNT_ZERO;
                     r_next.execute_in_place    = (shiftNew[7:4] == sfw_pkg::XIP_NIBBLE);
                     r_next.xipCmd = r_reg.cmd;
                     r_next.state  = sfw_pkg::ST_DATA;
                  end
               end
            end
            sfw_pkg::ST_DATA: begin
               if (sample) begin
                  r_next.shift  = shiftNew;
                  r_next.bitCnt = cntNext;
                  if (cntNext == sfw_pkg::BYTE_BITS) begin
                     // no page boundary: the burst runs as long as select stays low
                     r_next.bitCnt = sfw_pkg::CNT_ZERO;
                     r_next.addr   = addrStep(r_reg.addr);
                  end
               end
            end
            sfw_pkg::ST_SKIP: r_next.state = sfw_pkg::ST_SKIP;
            default:          r_next.state = sfw_pkg::ST_IDLE;
         endcase
      end
   end

   // single register stage for the whole engine
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         r_reg         <= '0;
         r_reg.csMeta  <= 1'b1;
         r_reg.csSafe  <= 1'b1;
         r_reg.state   <= sfw_pkg::ST_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs come straight from the state register
   assign memWrValid = r_reg.outValid;
   assign memWrAddr  = r_reg.outWord.addr;
   assign memWrData  = r_reg.outWord.data;
   assign xipActive  = r_reg.execute_in_place;
   assign overrun    = r_reg.overrun;
   assign busy       = (r_reg.state != sfw_pkg::ST_IDLE);

   a_cs_abort: assert property (@(posedge ref_clk) disable iff (!resetn)
      !csActive |=> r_reg.state == sfw_pkg::ST_IDLE && r_reg.bitCnt == sfw_pkg::CNT_ZERO)
      else $error("select high did not abort the frame");

   a_push_whole: assert property (@(posedge ref_clk) disable iff (!resetn)
      pushReq |-> r_reg.state == sfw_pkg::ST_DATA && cntNext == sfw_pkg::BYTE_BITS && csActive)
      else $error("byte pushed before eight bits");

   a_prot_block: assert property (@(posedge ref_clk) disable iff (!resetn)
      pushReq |-> !isProt(pushWord.addr, protEn, protLo, protHi))
      else $error("write into protected block");

   a_addr_step: assert property (@(posedge ref_clk) disable iff (!resetn)
      (r_reg.state == sfw_pkg::ST_DATA && sample && cntNext == sfw_pkg::BYTE_BITS
       && r_reg.addr != sfw_pkg::ADDR_TOP) |=> r_reg.addr == $past(r_reg.addr) + sfw_pkg::ADDR_ONE)
      else $error("address did not step after a byte");

   a_addr_wrap: assert property (@(posedge ref_clk) disable iff (!resetn)
      (r_reg.state == sfw_pkg::ST_DATA && sample && cntNext == sfw_pkg::BYTE_BITS
       && r_reg.addr == sfw_pkg::ADDR_TOP) |=> r_reg.addr == sfw_pkg::ADDR_ZERO)
      else $error("address did not wrap to zero");

   a_wel_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
      (r_reg.state == sfw_pkg::ST_OPCODE && sample && cntNext == sfw_pkg::BYTE_BITS
       && !writeEnableLatch && csActive) |=> r_reg.state == sfw_pkg::ST_SKIP)
      else $error("write accepted with latch clear");

   a_ddr_quad: assert property (@(posedge ref_clk) disable iff (!resetn)
      (r_reg.state == sfw_pkg::ST_OPCODE && sample && cntNext == sfw_pkg::BYTE_BITS
       && shiftNew[7:0] == sfw_pkg::OP_DDR_WRITE && !quadLaneProtocol && csActive)
      |=> r_reg.state == sfw_pkg::ST_SKIP)
      else $error("double rate write outside quad protocol");

   a_xip_enter: assert property (@(posedge ref_clk) disable iff (!resetn)
      (r_reg.state == sfw_pkg::ST_MODE && sample && cntNext == sfw_pkg::BYTE_BITS && csActive
       && shiftNew[7:4] == sfw_pkg::XIP_NIBBLE) |=> r_reg.execute_in_place)
      else $error("continuous mode not entered");

   a_xip_exit: assert property (@(posedge ref_clk) disable iff (!resetn)
      (r_reg.state == sfw_pkg::ST_MODE && sample && cntNext == sfw_pkg::BYTE_BITS && csActive
       && shiftNew[7:4] != sfw_pkg::XIP_NIBBLE) |=> !r_reg.execute_in_place && r_reg.state == sfw_pkg::ST_DATA)
      else $error("continuous mode not left");

   a_no_opcode_xip: assert property (@(posedge ref_clk) disable iff (!resetn)
      (r_reg.state == sfw_pkg::ST_IDLE && csActive && r_reg.execute_in_place)
      |=> r_reg.state inside {sfw_pkg::ST_ADDR, sfw_pkg::ST_SKIP, sfw_pkg::ST_IDLE})
      else $error("continuous frame expected an opcode");

endmodule

// >>> bench/sfw_host_model.sv
// Purpose: host side model driving select, serial clock and lanes
// Assumes: clock mode 0, half period of four ref_clk cycles
// Notes:   released lanes show the inverse of their last value
`timescale 1ns/100ps
module sfw_host_model (
   input  wire logic ref_clk,
   output logic      csN,
   output logic      sck,
   output logic [3:0] ioIn
);
   // idle pins; clock rests low, mode 0 only
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      ioIn = 4'h0;
   end
   // lanes move two cycles ahead of the toggle that opens each beat, so both edges see them settled
   task automatic beat(input logic [3:0] d, input bit ddr);
      repeat (2) @(negedge ref_clk);
      ioIn = d;
      repeat (2) @(negedge ref_clk);
      sck = ~sck;
      if (!ddr) begin
         repeat (4) @(negedge ref_clk);
         sck = ~sck;
      end
   endtask
   // msb first: two lanes put bit 7 on io1, four lanes bit 7 on io3
   task automatic send(input logic [31:0] v, input int n, input int lanes, input bit ddr);
      for (int i = 0; i < n / lanes; i++) begin
         beat(v[31:28] >> (4 - lanes), ddr);
         v = v << lanes;
      end
   endtask
   // select low, then a short setup before the first edge
   task automatic open_frame();
      @(negedge ref_clk);
      csN = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask
   // select rises four cycles after the last clock edge; lanes flip so no stale value lingers
   task automatic close_frame();
      repeat (4) @(negedge ref_clk);
      csN = 1'b1;
      ioIn = ~ioIn;
      repeat (6) @(negedge ref_clk);
   endtask
endmodule

// >>> bench/sfw_write_path_test.sv
// Purpose: self-checking bench of the serial write path
// Assumes: host model drives the pins; array side ready unless stalled
// Notes:   array writes are queued by a monitor and popped in order
`timescale 1ns/100ps
module sfw_write_path_test;
   logic        ref_clk, resetn, dual, quad, write_enable_latch, protEn, memWrReady;
   logic        csN, sck, memWrValid, xipActive, overrun, busy;
   logic [3:0]  ioIn;
   logic [17:0] protLo, protHi, memWrAddr;
   logic [7:0]  memWrData;
   logic [25:0] got[$];
   int          miscompares, checks_done;

   sfw_host_model i_host (.ref_clk(ref_clk), .csN(csN), .sck(sck), .ioIn(ioIn));
   sfw_write_path i_dut (.ref_clk(ref_clk), .resetn(resetn), .csN(csN), .sck(sck), .ioIn(ioIn),
      .dualLaneProtocol(dual), .quadLaneProtocol(quad), .writeEnableLatch(write_enable_latch), .protEn(protEn),
      .protLo(protLo), .protHi(protHi), .memWrReady(memWrReady), .memWrValid(memWrValid),
      .memWrAddr(memWrAddr), .memWrData(memWrData), .xipActive(xipActive), .overrun(overrun), .busy(busy));

   // 250 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // collect every word the array takes
   always @(posedge ref_clk)
      if (memWrValid === 1'b1 && memWrReady === 1'b1) got.push_back({memWrAddr, memWrData});

   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // an empty queue yields unknown so a missing word never matches
   task automatic chk_word(input logic [17:0] a, input logic [7:0] d);
      logic [25:0] w;
      w = 26'bx;
      if (got.size() > 0) w = got.pop_front();
      checks_done++;
      if (w !== {a, d}) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, w, {a, d});
      end
   endtask
   task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one frame; op 0 means a continuous frame without opcode; part adds a cut-off byte
   task automatic frame(input logic [7:0] op, input logic [23:0] a, input int al, input int dl, input bit ddr,
                        input bit hasM, input logic [7:0] m, input int nb, input logic [7:0] d0, input int part);
      i_host.open_frame();
      if (op !== 8'h00) i_host.send({op, 24'h0}, 8, quad ? 4 : dual ? 2 : 1, 1'b0);
      i_host.send({a, 8'h0}, 24, al, ddr);
      if (hasM) i_host.send({m, 24'h0}, 8, al, ddr);
      for (int i = 0; i < nb; i++) i_host.send({d0 + 8'(i), 24'h0}, 8, dl, ddr);
      if (part > 0) i_host.send(32'hFFFF_FFFF, part, dl, ddr);
      i_host.close_frame();
      repeat (12) @(negedge ref_clk);
   endtask

   task automatic t_basic();
      frame(8'h02, 24'hFC_0005, 1, 1, 0, 0, 8'h00, 2, 8'h3C, 4);
      chk_word(18'h0_0005, 8'h3C);
      chk_word(18'h0_0006, 8'h3D);
      chk_val(got.size(), 0);
      frame(8'h02, 24'h03_FFFF, 1, 1, 0, 0, 8'h00, 2, 8'hA0, 0);
      chk_word(18'h3_FFFF, 8'hA0);
      chk_word(18'h0_0000, 8'hA1);
   endtask
   // latch clear: both a basic and an extended write vanish
   task automatic t_gate();
      write_enable_latch = 1'b0;
      frame(8'h02, 24'h00_0010, 1, 1, 0, 0, 8'h00, 1, 8'h11, 0);
      frame(8'hA2, 24'h00_0010, 1, 2, 0, 1, 8'h00, 1, 8'h22, 0);
      chk_val(got.size(), 0);
      write_enable_latch = 1'b1;
   endtask
   task automatic t_prot();
      protEn = 1'b1;
      protLo = 18'h0_0010;
      protHi = 18'h0_0010;
      frame(8'h02, 24'h00_000F, 1, 1, 0, 0, 8'h00, 3, 8'h50, 0);
      chk_word(18'h0_000F, 8'h50);
      chk_word(18'h0_0011, 8'h52);
      frame(8'hDA, 24'h00_0010, 1, 1, 0, 1, 8'h00, 2, 8'h60, 0);
      chk_word(18'h0_0011, 8'h61);
      protEn = 1'b0;
   endtask
   // every extended write in single protocol, with a mode byte
   task automatic t_modes();
      logic [7:0] ops [5] = '{8'hA2, 8'hA1, 8'h32, 8'hD2, 8'hD1};
      int         al [5]  = '{1, 2, 1, 4, 4};
      int         dl [5]  = '{2, 2, 4, 4, 4};
      for (int i = 0; i < 5; i++) begin
         frame(ops[i], 24'h00_0020 + 24'(i), al[i], dl[i], i == 4, 1, 8'h00, 1, 8'hC3 + 8'(i), 0);
         chk_word(18'h0_0020 + 18'(i), 8'hC3 + 8'(i));
      end
   endtask
   task automatic t_wide();
      dual = 1'b1;
      frame(8'h02, 24'h00_0040, 2, 2, 0, 0, 8'h00, 1, 8'h96, 0);
      chk_word(18'h0_0040, 8'h96);
      quad = 1'b1;
      frame(8'hDE, 24'h03_FFFF, 4, 4, 1, 0, 8'h00, 2, 8'h5A, 0);
      chk_word(18'h3_FFFF, 8'h5A);
      chk_word(18'h0_0000, 8'h5B);
      frame(8'hDD, 24'h00_0060, 4, 4, 1, 1, 8'hA5, 1, 8'h77, 0);
      chk_word(18'h0_0060, 8'h77);
      chk_val(xipActive, 1);
      frame(8'h00, 24'h00_0070, 4, 4, 1, 1, 8'h00, 1, 8'h78, 0);
      chk_word(18'h0_0070, 8'h78);
      chk_val(xipActive, 0);
      frame(8'h02, 24'h00_0080, 4, 4, 0, 0, 8'h00, 1, 8'hE1, 0);
      chk_word(18'h0_0080, 8'hE1);
      quad = 1'b0;
      dual = 1'b0;
   endtask
   // array stalls while a long burst overfills the buffer
   task automatic t_fill();
      memWrReady = 1'b0;
      frame(8'h02, 24'h00_0200, 1, 1, 0, 0, 8'h00, 18, 8'h00, 0);
      chk_val(overrun, 1);
      chk_val(got.size(), 0);
      memWrReady = 1'b1;
      repeat (40) @(negedge ref_clk);
      chk_word(18'h0_0200, 8'h00);
   endtask

   // reset, then the scenarios in turn
   initial begin
      resetn = 1'b0;
      {dual, quad, protEn} = 3'h0;
      write_enable_latch = 1'b1;
      memWrReady = 1'b1;
      protLo = 18'h0_0000;
      protHi = 18'h0_0000;
      repeat (4) @(negedge ref_clk);
      resetn = 1'b1;
      chk_val({busy, xipActive, overrun, memWrValid}, 0);
      t_basic();
      t_gate();
      t_prot();
      t_modes();
      t_wide();
      t_fill();
      // a second reset in mid-run must clear the sticky overrun flag
      resetn = 1'b0;
      repeat (4) @(negedge ref_clk);
      resetn = 1'b1;
      chk_val({busy, xipActive, overrun, memWrValid}, 0);
      tally_and_finish();
   end
   // the whole run takes well under this; a hang is cut short here
   initial begin
      repeat (60000) @(posedge ref_clk);
      miscompares++;
      tally_and_finish();
   end
endmodule
